// file: bus_pins_pkg.sv
// constants shared by the card end and the host end of the isa/pcmcia pins
package bus_pins_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 100;
    localparam int RESET_MIN_NS     = 100;
    localparam int RESET_MIN_CYC    = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_MS           = 15;
    localparam int POR_CYC          = (POR_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IREQ_LOW_MAX_US  = 10;
    localparam int IREQ_LOW_MAX_CYC = (IREQ_LOW_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int RING_TIMEOUT_MS  = 75;
    localparam int RING_TIMEOUT_CYC = (RING_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
    localparam int STROBE_MIN_NS    = 200;
    localparam int STROBE_MIN_CYC   = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int ADDR_W           = 16;
    localparam int DATA_W           = 16;
    localparam int IRQ_LINES        = 4;
    localparam int BASE_LSB         = 4;
    localparam logic MODE_RST_ISA   = 1'b1;
    // ------------------------------------------------------------
    // host command kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_IO_RD   = 3'h0,
        CMD_IO_WR   = 3'h1,
        CMD_MEM_RD  = 3'h2,
        CMD_ATTR_RD = 3'h3,
        CMD_ATTR_WR = 3'h4
    } cmd_type;
endpackage

// file: bus_pins_if.sv
// pin bundle between the card and the host, with wire resolution
`timescale 1ns/10ps
`default_nettype none
interface bus_pins_if;
    // host driven
    logic        reset_pin;
    logic [15:0] addr;
    logic        aen_reg;
    logic        sbhe_n;
    logic        bale_we;
    logic        iord_n;
    logic        iowr_n;
    logic        memr_oe_n;
    logic [15:0] host_data;
    logic        host_data_oe_n;
    logic        strap_host_out;
    logic        strap_host_oe_n;
    // card driven
    logic [15:0] dev_data;
    logic        dev_data_oe_n;
    logic [3:0]  irq_out;
    logic [3:0]  irq_oe_n;
    logic        rdy_oe_n;
    logic        cs16_oe_n;
    logic        strap_dev_out;
    logic        strap_dev_oe_n;
    // resolved wire levels
    logic [15:0] data;
    logic [3:0]  irq_level;
    logic        rdy_level;
    logic        cs16_level;
    logic        strap_level;

    // weak pullups on data, strap and open-drain pins; undriven irq reads low
    assign data        = !dev_data_oe_n ? dev_data :
                         (!host_data_oe_n ? host_data : 16'hffff);
    assign rdy_level   = rdy_oe_n;
    assign cs16_level  = cs16_oe_n;
    assign strap_level = !strap_dev_oe_n ? strap_dev_out :
                         (!strap_host_oe_n ? strap_host_out : 1'b1);
    for (genvar k = 0; k < 4; k++) begin : g_irq
        assign irq_level[k] = !irq_oe_n[k] ? irq_out[k] : 1'b0;
    end

    modport card (
        input  reset_pin, addr, aen_reg, sbhe_n, bale_we, iord_n, iowr_n, memr_oe_n,
        input  data, strap_level,
        output dev_data, dev_data_oe_n, irq_out, irq_oe_n, rdy_oe_n, cs16_oe_n,
        output strap_dev_out, strap_dev_oe_n
    );
    modport host (
        output reset_pin, addr, aen_reg, sbhe_n, bale_we, iord_n, iowr_n, memr_oe_n,
        output host_data, host_data_oe_n, strap_host_out, strap_host_oe_n,
        input  data, irq_level, rdy_level, cs16_level
    );
endinterface
`default_nettype wire

// file: card_pins_end.sv
// card end: reset, decode, strobes, 16-bit, wait, irq steering, status change
//
// Overview of operation
// - reset pin counts only after 100 ns high
// - power-on reset lasts at least 15 ms
// - hardware reset is por or filtered pin
// - isa latches address and sbhe at bale fall
// - isa irq on one of four lines
// - unselected isa irq lines are floated
// - pcmcia irq on single active-low request
// - pcmcia request low until card info loaded
// - pcmcia input acknowledge on enabled reads
// - status change shows ringing or modem changed
// - ring input stretched into steady ringing level
// - isa 16-bit indication on aen low match
// - pcmcia 16-bit indication with function and reg
// - card may stretch cycles through ready/wait
// - host uses separate read and write strobes
// - 16-bit data bus, card drives on io reads only
// - isa host reads boot rom by memory read
// - pcmcia host reads attributes by output enable
// - pcmcia host writes attributes by write enable
// - strap sampled at reset end selects mode
// - isa decode only while aen low
`timescale 1ns/10ps
`default_nettype none
module card_pins_end #(
    parameter int POR_CYC  = bus_pins_pkg::POR_CYC,
    parameter int RING_CYC = bus_pins_pkg::RING_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // pins
    bus_pins_if.card         pins,
    // configuration
    input  wire logic        i_mode_16bit,
    input  wire logic [1:0]  i_irq_line_select,
    input  wire logic        i_ring_status_select,
    input  wire logic        i_function_active,
    input  wire logic [11:0] i_isa_base,
    input  wire logic [11:0] i_pcmcia_base,
    // card status
    input  wire logic        i_irq_request,
    input  wire logic        i_modem_changed,
    input  wire logic        i_modem_ring_input,
    input  wire logic        i_cis_loaded,
    input  wire logic        i_busy,
    input  wire logic [15:0] i_read_data,
    // decoded cycles
    output logic             o_hw_reset,
    output logic             o_isa_mode,
    output logic [15:0]      o_addr,
    output logic             o_sbhe_n,
    output logic             o_rd_strobe,
    output logic             o_wr_strobe,
    output logic [15:0]      o_wr_data,
    output logic             o_rom_read,
    output logic             o_attr_read,
    output logic             o_attr_write,
    output logic             o_ringing
);
    localparam int RST_W  = $clog2(bus_pins_pkg::RESET_MIN_CYC + 1);
    localparam int POR_W  = $clog2(POR_CYC + 1);
    localparam int RING_W = $clog2(RING_CYC + 1);
    localparam logic [RST_W-1:0]  RST_MIN  = RST_W'(bus_pins_pkg::RESET_MIN_CYC);
    localparam logic [POR_W-1:0]  POR_LAST = POR_W'(POR_CYC - 1);
    localparam logic [RING_W-1:0] RING_LD  = RING_W'(RING_CYC);

    function automatic logic base_hit(input logic [15:0] a, input logic [11:0] base);
        base_hit = (a[15:bus_pins_pkg::BASE_LSB] == base);
    endfunction

    logic              rst_meta_ff;
    logic              rst_sync_ff;
    logic [RST_W-1:0]  rst_cnt_ff;
    logic [POR_W-1:0]  por_cnt_ff;
    logic              por_active_ff;
    logic              ext_reset;
    logic              hw_reset;
    logic              isa_mode_ff;
    logic [15:0]       addr_lat_ff;
    logic              sbhe_lat_ff;
    logic [15:0]       addr_eff;
    logic              io_hit;
    logic              rd_cyc;
    logic              wr_cyc;
    logic              rd_prev_ff;
    logic              wr_prev_ff;
    logic              we_prev_ff;
    logic [15:0]       rdata_ff;
    logic [15:0]       wdata_ff;
    logic              rd_pulse_ff;
    logic              wr_pulse_ff;
    logic              attr_wr_ff;
    logic              card_ready_ff;
    logic              ring_meta_ff;
    logic              ring_sync_ff;
    logic              ring_prev_ff;
    logic [RING_W-1:0] ring_cnt_ff;
    logic              ringing;
    logic [3:0]        pc_irq;

    // ------------------------------------------------------------
    // reset qualification and power-on reset
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
            rst_cnt_ff  <= '0;
        end else begin
            rst_meta_ff <= pins.reset_pin;
            rst_sync_ff <= rst_meta_ff;
            if (!rst_sync_ff) begin
                rst_cnt_ff <= '0;
            end else if (rst_cnt_ff != RST_MIN) begin
                rst_cnt_ff <= rst_cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            por_cnt_ff    <= '0;
            por_active_ff <= 1'b1;
        end else if (por_active_ff) begin
            por_cnt_ff <= por_cnt_ff + 1'b1;
            if (por_cnt_ff == POR_LAST) begin
                por_active_ff <= 1'b0;
            end
        end
    end

    assign ext_reset  = (rst_cnt_ff == RST_MIN);
    assign hw_reset   = por_active_ff | ext_reset;
    assign o_hw_reset = hw_reset;

    // strap is read every reset cycle, so the value at release is kept
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            isa_mode_ff <= bus_pins_pkg::MODE_RST_ISA;
        end else if (hw_reset) begin
            isa_mode_ff <= pins.strap_level;
        end
    end
    assign o_isa_mode = isa_mode_ff;

    // ------------------------------------------------------------
    // address latch and decode
    // ------------------------------------------------------------
    // transparent while bale is high, so the held value is the one at its fall
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            addr_lat_ff <= '0;
            sbhe_lat_ff <= 1'b1;
        end else if (isa_mode_ff && pins.bale_we) begin
            addr_lat_ff <= pins.addr;
            sbhe_lat_ff <= pins.sbhe_n;
        end
    end

    assign addr_eff = isa_mode_ff ? addr_lat_ff : pins.addr;
    assign o_addr   = addr_eff;
    assign o_sbhe_n = isa_mode_ff ? sbhe_lat_ff : 1'b0;

    always_comb begin
        if (hw_reset) begin
            io_hit = 1'b0;
        end else if (isa_mode_ff) begin
            io_hit = !pins.aen_reg && base_hit(addr_eff, i_isa_base);
        end else begin
            io_hit = i_function_active && !pins.aen_reg && base_hit(addr_eff, i_pcmcia_base);
        end
    end

    assign rd_cyc = io_hit && !pins.iord_n;
    assign wr_cyc = io_hit && !pins.iowr_n;

    // ------------------------------------------------------------
    // data bus and strobes
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rdata_ff    <= '0;
            wdata_ff    <= '0;
            rd_prev_ff  <= 1'b0;
            wr_prev_ff  <= 1'b0;
            we_prev_ff  <= 1'b1;
            rd_pulse_ff <= 1'b0;
            wr_pulse_ff <= 1'b0;
            attr_wr_ff  <= 1'b0;
        end else begin
            rdata_ff    <= i_read_data;
            rd_prev_ff  <= rd_cyc;
            wr_prev_ff  <= wr_cyc;
            we_prev_ff  <= pins.bale_we;
            rd_pulse_ff <= rd_cyc && !rd_prev_ff;
            wr_pulse_ff <= wr_prev_ff && !wr_cyc;
            attr_wr_ff  <= !isa_mode_ff && !hw_reset && !pins.aen_reg
                           && !we_prev_ff && pins.bale_we;
            if (wr_cyc || (!isa_mode_ff && !pins.bale_we)) begin
                wdata_ff <= pins.data;
            end
        end
    end

    assign pins.dev_data      = rdata_ff;
    assign pins.dev_data_oe_n = !rd_cyc;
    assign o_rd_strobe        = rd_pulse_ff;
    assign o_wr_strobe        = wr_pulse_ff;
    assign o_wr_data          = wdata_ff;
    assign o_attr_write       = attr_wr_ff;
    assign o_rom_read         = isa_mode_ff && !hw_reset && !pins.memr_oe_n
                                && !pins.aen_reg;
    assign o_attr_read        = !isa_mode_ff && !hw_reset && !pins.memr_oe_n
                                && !pins.aen_reg;

    // strap pin turns into the active-low rom select once in isa mode
    assign pins.strap_dev_out  = !o_rom_read;
    assign pins.strap_dev_oe_n = !(isa_mode_ff && !hw_reset);

    // ------------------------------------------------------------
    // 16-bit indication and cycle extension
    // ------------------------------------------------------------
    assign pins.cs16_oe_n = !(i_mode_16bit && io_hit);
    assign pins.rdy_oe_n  = !(i_busy && (rd_cyc || wr_cyc));

    // ------------------------------------------------------------
    // ring stretcher
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ring_meta_ff <= 1'b0;
            ring_sync_ff <= 1'b0;
            ring_prev_ff <= 1'b0;
            ring_cnt_ff  <= '0;
        end else begin
            ring_meta_ff <= i_modem_ring_input;
            ring_sync_ff <= ring_meta_ff;
            ring_prev_ff <= ring_sync_ff;
            if (ring_sync_ff != ring_prev_ff) begin
                ring_cnt_ff <= RING_LD;
            end else if (ring_cnt_ff != '0) begin
                ring_cnt_ff <= ring_cnt_ff - 1'b1;
            end
        end
    end
    assign ringing   = (ring_cnt_ff != '0);
    assign o_ringing = ringing;

    // ------------------------------------------------------------
    // interrupt lines
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || hw_reset) begin
            card_ready_ff <= 1'b0;
        end else if (i_cis_loaded) begin
            card_ready_ff <= 1'b1;
        end
    end

    assign pc_irq[0] = card_ready_ff && !i_irq_request;
    assign pc_irq[1] = !rd_cyc;
    assign pc_irq[2] = i_ring_status_select ? !ringing : !i_modem_changed;
    assign pc_irq[3] = 1'b1;

    for (genvar k = 0; k < bus_pins_pkg::IRQ_LINES; k++) begin : g_irq
        always_comb begin
            if (isa_mode_ff) begin
                pins.irq_out[k]  = i_irq_request;
                pins.irq_oe_n[k] = hw_reset || (i_irq_line_select != 2'(k));
            end else begin
                pins.irq_out[k]  = pc_irq[k];
                pins.irq_oe_n[k] = (k == 3);
            end
        end
    end
endmodule
`default_nettype wire

// file: host_pins_end.sv
// host end: drives reset, strap and one bus cycle per command
`timescale 1ns/10ps
`default_nettype none
module host_pins_end #(
    parameter int STROBE_CYC = bus_pins_pkg::STROBE_MIN_CYC
) (
    // clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_n,
    // pins
    bus_pins_if.host                   pins,
    // setup
    input  wire logic                  i_pcmcia_mode,
    input  wire logic                  i_assert_reset,
    // command
    input  wire logic                  i_cmd_valid,
    input  wire bus_pins_pkg::cmd_type i_cmd_kind,
    input  wire logic [15:0]           i_cmd_addr,
    input  wire logic [15:0]           i_cmd_wdata,
    output logic                       o_cmd_ready,
    output logic                       o_done,
    output logic [15:0]                o_rdata,
    // card status
    output logic [3:0]                 o_irq_level,
    output logic                       o_cs16_seen
);
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ADDR   = 2'b01,
        ST_STROBE = 2'b10,
        ST_HOLD   = 2'b11
    } state_type;

    localparam logic [7:0] STB_LAST = 8'(STROBE_CYC - 1);

    state_type             state_ff;
    bus_pins_pkg::cmd_type kind_ff;
    logic [15:0]           addr_ff;
    logic [15:0]           wdata_ff;
    logic [15:0]           rdata_ff;
    logic [7:0]            stb_cnt_ff;
    logic                  done_ff;
    logic                  cs16_ff;
    logic                  reset_pin_ff;
    logic                  stb;

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_ff   <= ST_IDLE;
            kind_ff    <= bus_pins_pkg::CMD_IO_RD;
            addr_ff    <= '0;
            wdata_ff   <= '0;
            stb_cnt_ff <= '0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (i_cmd_valid) begin
                        kind_ff  <= i_cmd_kind;
                        addr_ff  <= i_cmd_addr;
                        wdata_ff <= i_cmd_wdata;
                        state_ff <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    stb_cnt_ff <= '0;
                    state_ff   <= ST_STROBE;
                end
                ST_STROBE: begin
                    if (stb_cnt_ff != STB_LAST) begin
                        stb_cnt_ff <= stb_cnt_ff + 1'b1;
                    end else if (pins.rdy_level) begin
                        state_ff <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rdata_ff     <= '0;
            done_ff      <= 1'b0;
            cs16_ff      <= 1'b0;
            reset_pin_ff <= 1'b0;
        end else begin
            reset_pin_ff <= i_assert_reset;
            done_ff      <= (state_ff == ST_HOLD);
            if (state_ff == ST_STROBE) begin
                rdata_ff <= pins.data;
                cs16_ff  <= !pins.cs16_level;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    assign stb = (state_ff == ST_STROBE);

    assign pins.reset_pin       = reset_pin_ff;
    assign pins.addr            = addr_ff;
    assign pins.sbhe_n          = 1'b0;
    assign pins.aen_reg         = (state_ff == ST_IDLE);
    assign pins.bale_we         = i_pcmcia_mode ? !(stb && kind_ff == bus_pins_pkg::CMD_ATTR_WR)
                                                : (state_ff == ST_ADDR);
    assign pins.iord_n          = !(stb && kind_ff == bus_pins_pkg::CMD_IO_RD);
    assign pins.iowr_n          = !(stb && kind_ff == bus_pins_pkg::CMD_IO_WR);
    assign pins.memr_oe_n       = !(stb && (kind_ff == bus_pins_pkg::CMD_MEM_RD
                                  || kind_ff == bus_pins_pkg::CMD_ATTR_RD));
    assign pins.host_data       = wdata_ff;
    assign pins.host_data_oe_n  = !(state_ff != ST_IDLE && (kind_ff == bus_pins_pkg::CMD_IO_WR
                                  || kind_ff == bus_pins_pkg::CMD_ATTR_WR));
    assign pins.strap_host_out  = 1'b0;
    assign pins.strap_host_oe_n = !i_pcmcia_mode;

    assign o_cmd_ready = (state_ff == ST_IDLE);
    assign o_done      = done_ff;
    assign o_rdata     = rdata_ff;
    assign o_irq_level = pins.irq_level;
    assign o_cs16_seen = cs16_ff;
endmodule
`default_nettype wire

// file: bus_pins_sva.sv
// assertions on the pins that join the card end and the host end
`timescale 1ns/10ps
`default_nettype none
module bus_pins_sva (
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    // pin levels
    input wire logic        reset_pin,
    input wire logic [15:0] addr,
    input wire logic        aen_reg,
    input wire logic        iord_n,
    input wire logic        iowr_n,
    input wire logic        host_data_oe_n,
    input wire logic        strap_host_oe_n,
    input wire logic        dev_data_oe_n,
    input wire logic [3:0]  irq_out,
    input wire logic [3:0]  irq_oe_n,
    input wire logic        rdy_oe_n,
    input wire logic        cs16_oe_n
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence rd_start;
        $fell(iord_n);
    endsequence
    sequence rd_held;
        !iord_n [*2];
    endsequence
    sequence ireq_low;
        !irq_oe_n[0] && !irq_out[0];
    endsequence
    irq_one_line_a: assert property (strap_host_oe_n |-> $countones(~irq_oe_n) <= 1)
        else $error("several isa irq lines driven");
    irq_d_float_a: assert property (!strap_host_oe_n |-> irq_oe_n[3])
        else $error("spare irq line driven");
    ireq_reset_a: assert property (($rose(reset_pin) && !strap_host_oe_n) |-> ##[1:8] ireq_low)
        else $error("request line not low in reset");
    wait_decode_a: assert property (!rdy_oe_n |-> !aen_reg)
        else $error("wait outside decoded cycle");
    cs16_decode_a: assert property (!cs16_oe_n |-> !aen_reg)
        else $error("16-bit indication without qualifier");
    data_on_read_a: assert property (!dev_data_oe_n |-> !iord_n)
        else $error("card drives data outside read");
    no_data_fight_a: assert property (!(!dev_data_oe_n && !host_data_oe_n))
        else $error("both ends drive data");
    one_strobe_a: assert property (!(!iord_n && !iowr_n))
        else $error("read and write strobes together");
    strobe_width_a: assert property (rd_start |-> rd_held)
        else $error("read strobe too short");
    addr_hold_a: assert property ((!iord_n && !$past(iord_n)) |-> $stable(addr))
        else $error("address moved in strobe");
endmodule
`default_nettype wire

// file: tb_isa_pcmcia_host_control_pins.sv
// self-checking bench joining the card end and host end over the pin bundle
`timescale 1ns/10ps
`default_nettype none
module tb_isa_pcmcia_host_control_pins;
    logic i_clock, i_rst_n, m16, rsel, fna, ireq, mchg, ring, cis, busy;
    logic hwr, isam, sbhe, rds, wrs, romr, atr, atw, rng, pcm, arst, vld, rdy, done, cs16;
    logic rom_seen, ar_seen, aw_seen, ack_seen;
    logic [1:0]  sel;
    logic [3:0]  irql;
    logic [15:0] rdin, caddr, wdat, wr_d, caddr_w, cwd, hrd;
    bus_pins_pkg::cmd_type kind;
    int n_mismatch, samples_checked, lat, n;
    bus_pins_if pins ();
    card_pins_end #(.POR_CYC(20), .RING_CYC(30)) card_pins_end_i (.i_clock, .i_rst_n,
        .pins(pins.card), .i_mode_16bit(m16), .i_irq_line_select(sel),
        .i_ring_status_select(rsel), .i_function_active(fna), .i_isa_base(12'h030),
        .i_pcmcia_base(12'h031), .i_irq_request(ireq), .i_modem_changed(mchg),
        .i_modem_ring_input(ring), .i_cis_loaded(cis), .i_busy(busy), .i_read_data(rdin),
        .o_hw_reset(hwr), .o_isa_mode(isam), .o_addr(caddr), .o_sbhe_n(sbhe),
        .o_rd_strobe(rds), .o_wr_strobe(wrs), .o_wr_data(wdat), .o_rom_read(romr),
        .o_attr_read(atr), .o_attr_write(atw), .o_ringing(rng));
    host_pins_end #(.STROBE_CYC(2)) host_pins_end_i (.i_clock, .i_rst_n, .pins(pins.host),
        .i_pcmcia_mode(pcm), .i_assert_reset(arst), .i_cmd_valid(vld), .i_cmd_kind(kind),
        .i_cmd_addr(caddr_w), .i_cmd_wdata(cwd), .o_cmd_ready(rdy), .o_done(done),
        .o_rdata(hrd), .o_irq_level(irql), .o_cs16_seen(cs16));
    bus_pins_sva chk_i (.i_clock, .i_rst_n, .reset_pin(pins.reset_pin), .addr(pins.addr),
        .aen_reg(pins.aen_reg), .iord_n(pins.iord_n), .iowr_n(pins.iowr_n),
        .host_data_oe_n(pins.host_data_oe_n), .strap_host_oe_n(pins.strap_host_oe_n),
        .dev_data_oe_n(pins.dev_data_oe_n), .irq_out(pins.irq_out), .irq_oe_n(pins.irq_oe_n),
        .rdy_oe_n(pins.rdy_oe_n), .cs16_oe_n(pins.cs16_oe_n));
    // ------------------------------------------------------------
    // tasks and monitors
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmd(input bus_pins_pkg::cmd_type k, input logic [15:0] a, input logic [15:0] d);
        @(negedge i_clock);
        vld = 1'b1;
        kind = k;
        caddr_w = a;
        cwd = d;
        @(negedge i_clock);
        vld = 1'b0;
        lat = 0;
        while (done !== 1'b1 && lat < 60) begin
            @(negedge i_clock);
            lat++;
        end
        if (lat == 60) n_mismatch++;
        @(negedge i_clock);
    endtask
    task automatic wait_reset_end();
        n = 0;
        while (hwr !== 1'b0 && n < 100) begin
            @(negedge i_clock);
            n++;
        end
        if (n == 100) n_mismatch++;
    endtask
    always @(posedge i_clock) begin
        if (wrs === 1'b1) wr_d <= wdat;
        if (romr === 1'b1) rom_seen <= 1'b1;
        if (atr === 1'b1) ar_seen <= 1'b1;
        if (atw === 1'b1) aw_seen <= 1'b1;
        if (isam === 1'b0 && hwr === 1'b0 && irql[1] === 1'b0) ack_seen <= 1'b1;
    end
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        n_mismatch++;
        complete_run();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {i_rst_n, m16, rsel, fna, ireq, mchg, ring, cis, busy, pcm, arst, vld} = '0;
        {rom_seen, ar_seen, aw_seen, ack_seen, sel, caddr_w, cwd, wr_d} = '0;
        rdin = 16'h5a3c;
        kind = bus_pins_pkg::CMD_IO_RD;
        repeat (3) @(negedge i_clock);
        i_rst_n = 1'b1;
        repeat (10) @(negedge i_clock);
        check("por", hwr, 16'h1);
        wait_reset_end();
        check("por_len", 16'(n >= 9), 16'h1);
        check("isa_mode", isam, 16'h1);
        m16 = 1'b1;
        cmd(bus_pins_pkg::CMD_IO_RD, 16'h0304, 16'h0);
        check("rd_data", hrd, 16'h5a3c);
        check("cs16_hit", cs16, 16'h1);
        check("latency", 16'(lat), 16'h4);
        cmd(bus_pins_pkg::CMD_IO_WR, 16'h0302, 16'hc3a5);
        check("wr_data", wr_d, 16'hc3a5);
        check("latched", caddr, 16'h0302);
        check("sbhe", sbhe, 16'h0);
        cmd(bus_pins_pkg::CMD_IO_RD, 16'h0404, 16'h0);
        check("miss_data", hrd, 16'hffff);
        check("cs16_miss", cs16, 16'h0);
        m16 = 1'b0;
        cmd(bus_pins_pkg::CMD_IO_RD, 16'h0304, 16'h0);
        check("cs16_8bit", cs16, 16'h0);
        busy = 1'b1;
        fork
            cmd(bus_pins_pkg::CMD_IO_RD, 16'h0300, 16'h0);
            begin
                repeat (8) @(negedge i_clock);
                busy = 1'b0;
            end
        join
        check("stretch", 16'(lat), 16'h8);
        cmd(bus_pins_pkg::CMD_MEM_RD, 16'h0000, 16'h0);
        check("rom_read", rom_seen, 16'h1);
        ireq = 1'b1;
        for (int s = 0; s < 4; s++) begin
            sel = 2'(s);
            repeat (2) @(negedge i_clock);
            check("irq_sel", 16'(irql), 16'h1 << s);
        end
        ireq = 1'b0;
        sel = 2'h0;
        for (int t = 0; t < 8; t++) begin
            repeat (5) @(negedge i_clock);
            ring = ~ring;
        end
        check("ringing", rng, 16'h1);
        repeat (40) @(negedge i_clock);
        check("ring_end", rng, 16'h0);
        pcm = 1'b1;
        arst = 1'b1;
        repeat (10) @(negedge i_clock);
        check("pin_reset", hwr, 16'h1);
        check("ireq_rst", irql[0], 16'h0);
        arst = 1'b0;
        wait_reset_end();
        check("pcm_mode", isam, 16'h0);
        check("not_ready", irql[0], 16'h0);
        cis = 1'b1;
        repeat (2) @(negedge i_clock);
        check("ready", irql[0], 16'h1);
        ireq = 1'b1;
        repeat (2) @(negedge i_clock);
        check("ireq", irql[0], 16'h0);
        ireq = 1'b0;
        m16 = 1'b1;
        for (int f = 1; f >= 0; f--) begin
            fna = 1'(f);
            ack_seen = 1'b0;
            cmd(bus_pins_pkg::CMD_IO_RD, 16'h0312, 16'h0);
            check("pcm_data", hrd, f ? 16'h5a3c : 16'hffff);
            check("pcm_cs16", cs16, 16'(f));
            check("inpack", ack_seen, 16'(f));
        end
        for (int r = 0; r < 4; r++) begin
            {rsel, mchg} = 2'(r);
            repeat (3) @(negedge i_clock);
            check("stschg", irql[2], rsel ? 16'h1 : 16'(!mchg));
        end
        cmd(bus_pins_pkg::CMD_ATTR_WR, 16'h0000, 16'h0041);
        check("attr_wr", aw_seen, 16'h1);
        cmd(bus_pins_pkg::CMD_ATTR_RD, 16'h0000, 16'h0);
        check("attr_rd", ar_seen, 16'h1);
        complete_run();
    end
endmodule
`default_nettype wire
